// file: sar_ctrl_pkg.sv
// shared constants and types for the successive-approximation control block
package sar_ctrl_pkg;

    localparam int          RESULT_W         = 8;
    localparam int          PHASE_DIV        = 8;
    localparam int          PHASE_W          = 3;
    localparam int          CONV_CYCLES      = 64;
    localparam int          DONE_HOLD_CYCLES = 8;
    localparam int          HOLD_W           = 4;
    localparam int          CONV_CNT_W       = 7;

    localparam logic [PHASE_W-1:0]    PHASE_LAST     = 3'h7;
    localparam logic [PHASE_W-1:0]    PHASE_RESET    = 3'h0;
    localparam logic [RESULT_W-1:0]   TRIAL_MSB      = 8'h80;
    localparam logic [RESULT_W-1:0]   TRIAL_LSB      = 8'h01;
    localparam logic [RESULT_W-1:0]   RESULT_RESET   = 8'h00;
    localparam logic [RESULT_W-1:0]   RESULT_ZERO    = 8'h00;
    localparam logic [HOLD_W-1:0]     HOLD_RESET     = 4'h0;
    localparam logic [HOLD_W-1:0]     HOLD_LOAD      = 4'(DONE_HOLD_CYCLES - 1);
    localparam logic [CONV_CNT_W-1:0] CONV_CNT_RESET = 7'h00;
    localparam logic [CONV_CNT_W-1:0] CONV_CNT_FULL  = 7'(CONV_CYCLES);

    // bus control pins, all active low
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } bus_ctrl_t;

    localparam bus_ctrl_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};

    // analog front-end answers
    typedef struct packed {
        logic keep_bit;
        logic neg_ge_pos;
    } comp_in_t;

    localparam comp_in_t COMP_RESET = '{keep_bit: 1'b0, neg_ge_pos: 1'b0};

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONVERT,
        ST_LATCH
    } conv_state_t;

endpackage

// file: sar_adc_start_read_control.sv
// conversion control and bus interface of an 8-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none

module sar_adc_start_read_control
    import sar_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_RESET,
    // bus control pins
    input  wire bus_ctrl_t           I_BUS,
    // comparator and input polarity
    input  wire comp_in_t            I_COMP,
    // ladder tap selection
    output logic [RESULT_W-1:0]      O_TRIAL_CODE,
    // data bus
    output logic [RESULT_W-1:0]      O_DATA,
    output logic                     O_DATA_OE_N,
    // end of conversion
    output logic                     O_CONVERSION_DONE_N
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    bus_ctrl_t             bus_meta_q;
    bus_ctrl_t             bus_sync_q;
    comp_in_t              comp_meta_q;
    comp_in_t              comp_sync_q;
    logic                  start_req;
    logic                  read_req;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            bus_meta_q  <= BUS_IDLE;
            bus_sync_q  <= BUS_IDLE;
            comp_meta_q <= COMP_RESET;
            comp_sync_q <= COMP_RESET;
        end else begin
            bus_meta_q  <= I_BUS;
            bus_sync_q  <= bus_meta_q;
            comp_meta_q <= I_COMP;
            comp_sync_q <= comp_meta_q;
        end
    end

    assign start_req = !bus_sync_q.cs_n && !bus_sync_q.wr_n;
    assign read_req  = !bus_sync_q.cs_n && !bus_sync_q.rd_n;

    ////////////////////////////////////////////////////////////////////////////
    // phase divider

    logic [PHASE_W-1:0]    phase_q;
    logic                  phase_tick;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            phase_q <= PHASE_RESET;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end

    assign phase_tick = (phase_q == PHASE_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    conv_state_t           state_q;
    logic [RESULT_W-1:0]   approximation_register_q;
    logic [RESULT_W-1:0]   mask_q;
    logic [RESULT_W-1:0]   result_q;
    logic [RESULT_W-1:0]   decided;
    logic                  last_bit;

    // drop the trial bit when the input is below the tap
    assign decided  = comp_sync_q.keep_bit ? approximation_register_q
                                           : (approximation_register_q & ~mask_q);
    assign last_bit = (mask_q == TRIAL_LSB);

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            state_q                  <= ST_IDLE;
            approximation_register_q <= RESULT_RESET;
            mask_q                   <= RESULT_RESET;
        end else if (start_req) begin
            state_q                  <= ST_ARMED;
            approximation_register_q <= RESULT_RESET;
            mask_q                   <= RESULT_RESET;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_ARMED: begin
                    if (phase_tick) begin
                        state_q                  <= ST_CONVERT;
                        approximation_register_q <= TRIAL_MSB;
                        mask_q                   <= TRIAL_MSB;
                    end
                end
                ST_CONVERT: begin
                    if (phase_tick) begin
                        if (last_bit) begin
                            state_q                  <= ST_LATCH;
                            approximation_register_q <= decided;
                            mask_q                   <= RESULT_RESET;
                        end else begin
                            approximation_register_q <= decided | (mask_q >> 1);
                            mask_q                   <= mask_q >> 1;
                        end
                    end
                end
                ST_LATCH: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // output latch takes the code the cycle before done falls
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            result_q <= RESULT_RESET;
        end else if (state_q == ST_CONVERT && phase_tick && last_bit && !start_req) begin
            result_q <= comp_sync_q.neg_ge_pos ? RESULT_ZERO : decided;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // done flag: set holds for eight clocks against read, start clears at once

    logic [HOLD_W-1:0]     hold_q;
    logic                  done_n_q;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            done_n_q <= 1'b1;
            hold_q   <= HOLD_RESET;
        end else if (state_q == ST_LATCH) begin
            done_n_q <= 1'b0;
            hold_q   <= HOLD_LOAD;
        end else if (start_req) begin
            done_n_q <= 1'b1;
            hold_q   <= HOLD_RESET;
        end else if (hold_q != HOLD_RESET) begin
            done_n_q <= 1'b0;
            hold_q   <= hold_q - 4'h1;
        end else if (read_req) begin
            done_n_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output registers

    logic                  oe_n_q;
    logic [RESULT_W-1:0]   data_q;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            oe_n_q <= 1'b1;
            data_q <= RESULT_RESET;
        end else begin
            oe_n_q <= !read_req;
            data_q <= result_q;
        end
    end

    assign O_TRIAL_CODE        = approximation_register_q;
    assign O_DATA              = data_q;
    assign O_DATA_OE_N         = oe_n_q;
    assign O_CONVERSION_DONE_N = done_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [CONV_CNT_W-1:0] conv_cnt_q;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET || state_q != ST_CONVERT) begin
            conv_cnt_q <= CONV_CNT_RESET;
        end else begin
            conv_cnt_q <= conv_cnt_q + 7'h01;
        end
    end

    AST_NEG_GIVES_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_q == ST_CONVERT && phase_tick && last_bit && !start_req && comp_sync_q.neg_ge_pos)
        |=> (result_q == RESULT_ZERO) ##1 (!O_CONVERSION_DONE_N))
        else $error("negative input did not give a zero code");

    AST_START_WITHIN_8: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_q == ST_ARMED && !start_req) |-> ##[1:8] (state_q != ST_ARMED || start_req))
        else $error("armed start did not begin within eight clocks");

    AST_HELD_IN_RESET: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        start_req [*3] |-> (state_q == ST_ARMED) && (approximation_register_q == RESULT_RESET))
        else $error("converter left reset while write strobe low");

    AST_LATCH_BEFORE_DONE: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        $fell(O_CONVERSION_DONE_N) |-> $past(state_q) == ST_LATCH && result_q == $past(result_q))
        else $error("done fell without the result latched one clock before");

    AST_SIXTY_FOUR_CLOCKS: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_q == ST_LATCH) |-> ($past(conv_cnt_q) == CONV_CNT_FULL - 7'h01) && mask_q == RESULT_RESET)
        else $error("conversion did not take sixty-four clocks");

    AST_MSB_FIRST: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        $rose(state_q == ST_CONVERT) |-> approximation_register_q == TRIAL_MSB)
        else $error("conversion did not test the top bit first");

    AST_READ_ENABLES: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        read_req |=> !O_DATA_OE_N && O_DATA == $past(result_q))
        else $error("read did not enable the data outputs");

    AST_READ_CLEARS: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (read_req && !start_req && hold_q == HOLD_RESET && state_q != ST_LATCH) |=> O_CONVERSION_DONE_N)
        else $error("read did not clear done");

    AST_FREE_RUN_SHORT: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (start_req && state_q != ST_LATCH) |=> O_CONVERSION_DONE_N && hold_q == HOLD_RESET)
        else $error("start did not end the done pulse");

    AST_ABORT: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_q == ST_CONVERT && start_req) |=> state_q == ST_ARMED && mask_q == RESULT_RESET)
        else $error("start did not abort the running conversion");

    AST_PHASE_STEP: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
        (state_q == ST_CONVERT && !phase_tick && !start_req) |=> $stable(approximation_register_q))
        else $error("register stepped off the divided phase");

endmodule

`default_nettype wire

// file: sar_bus_master.sv
// bus master model driving select and strobes of the converter
`timescale 1ns/1ps
`default_nettype none

module sar_bus_master
    import sar_ctrl_pkg::*;
(
    // clock
    input  wire logic                clk,
    // converter answers
    input  wire logic                done_n,
    input  wire logic                oe_n,
    input  wire logic [RESULT_W-1:0] data,
    // bus pins
    output var bus_ctrl_t            bus
);
    bus_ctrl_t drv        = BUS_IDLE;
    logic      free_run   = 1'b0;
    int        since_done = 0;

    always @(posedge clk) begin
        since_done <= done_n ? 0 : since_done + 1;
    end

    // done fed back to write strobe, select and read from drv
    assign bus = free_run ? bus_ctrl_t'{cs_n: drv.cs_n, rd_n: drv.rd_n, wr_n: done_n} : drv;

    // free-running mode: select held low, write follows done
    task automatic set_free_run(input bit on);
        @(negedge clk) drv.cs_n = !on;
        free_run = on;
    endtask

    // first call after power-up is the required start pulse
    task automatic do_start(input int len);
        @(negedge clk) drv.cs_n = 1'b0;
        @(negedge clk) drv.wr_n = 1'b0;
        repeat (len) @(negedge clk);
        drv.wr_n = 1'b1;
        @(negedge clk) drv.cs_n = 1'b1;
    endtask

    // early skips the wait after done falls
    task automatic do_read(input bit early, output logic [RESULT_W-1:0] d, output logic oe_seen);
        int n;
        n = 0;
        while (!early && since_done < DONE_HOLD_CYCLES && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk) drv = bus_ctrl_t'{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1};
        repeat (4) @(negedge clk);
        d       = data;
        oe_seen = oe_n;
        drv     = BUS_IDLE;
    endtask
endmodule

`default_nettype wire

// file: sar_adc_start_read_control_tb_top.sv
// self-checking testbench of the conversion control block
`timescale 1ns/1ps
`default_nettype none

module sar_adc_start_read_control_tb_top;
    import sar_ctrl_pkg::*;

    logic                clk    = 1'b0;
    logic                rst    = 1'b1;
    logic [RESULT_W-1:0] target = 8'h00;
    logic                neg_ge = 1'b0;
    bus_ctrl_t           bus;
    comp_in_t            comp;
    logic [RESULT_W-1:0] trial;
    logic [RESULT_W-1:0] data;
    logic                oe_n;
    logic                done_n;
    int                  checks      = 0;
    int                  miscompares = 0;
    logic [7:0]          tgt [4]     = '{8'hff, 8'h00, 8'ha5, 8'h5a};

    always #25 clk = ~clk;

    // comparator stands in for the analog input at value target
    assign comp = comp_in_t'{keep_bit: (target >= trial), neg_ge_pos: neg_ge};

    sar_adc_start_read_control DUT (
        .I_CLK_SYS(clk), .I_RESET(rst), .I_BUS(bus), .I_COMP(comp),
        .O_TRIAL_CODE(trial), .O_DATA(data), .O_DATA_OE_N(oe_n), .O_CONVERSION_DONE_N(done_n)
    );

    sar_bus_master master (.clk(clk), .done_n(done_n), .oe_n(oe_n), .data(data), .bus(bus));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (done_n !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_conv(input logic [7:0] t, input logic ng, input logic [7:0] exp);
        int         n;
        logic [7:0] d;
        logic       oe;
        target = t;
        neg_ge = ng;
        master.do_start(4);
        n = 0;
        while (trial !== TRIAL_MSB && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("start_delay", n <= 11, 1);
        wait_done(n);
        check("conv_cycles", n >= 63 && n <= 68, 1);
        check("result", data, exp);
        master.do_read(1'b0, d, oe);
        check("read_data", d, exp);
        check("read_oe_n", oe, 0);
        repeat (2) @(negedge clk);
        check("done_cleared", done_n, 1);
        repeat (2) @(negedge clk);
        check("oe_released", oe_n, 1);
    endtask

    task automatic test_hold();
        int n;
        target = 8'h81;
        neg_ge = 1'b0;
        fork
            master.do_start(40);
            begin
                repeat (30) @(negedge clk);
                check("held_trial", trial, 0);
                check("held_done_n", done_n, 1);
            end
        join
        wait_done(n);
        check("held_result", data, 8'h81);
    endtask

    task automatic test_abort();
        int n;
        target = 8'h3c;
        master.do_start(4);
        repeat (30) @(negedge clk);
        target = 8'hc3;
        master.do_start(4);
        wait_done(n);
        check("abort_cycles", n >= 64, 1);
        check("abort_result", data, 8'hc3);
    endtask

    task automatic test_early_read();
        int         n;
        logic [7:0] d;
        logic       oe;
        target = 8'h42;
        master.do_start(4);
        wait_done(n);
        master.do_read(1'b1, d, oe);
        repeat (6) @(negedge clk);
        check("done_held", done_n, 0);
        master.do_read(1'b0, d, oe);
        repeat (2) @(negedge clk);
        check("done_late_read", done_n, 1);
    endtask

    task automatic test_free_run();
        int n;
        int falls;
        int wid;
        int maxw;
        falls = 0;
        wid   = 0;
        maxw  = 0;
        master.do_start(4);
        wait_done(n);
        master.set_free_run(1'b1);
        repeat (300) begin
            @(negedge clk);
            if (done_n === 1'b0) begin
                wid++;
                if (wid == 1) falls++;
                if (falls >= 2 && wid > maxw) maxw = wid;
            end
            else wid = 0;
        end
        master.set_free_run(1'b0);
        check("free_run_count", falls >= 3, 1);
        check("free_run_width", maxw >= 1 && maxw <= 4, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        foreach (tgt[i]) run_conv(tgt[i], 1'b0, tgt[i]);
        run_conv(8'ha5, 1'b1, RESULT_ZERO);
        test_hold();
        test_abort();
        test_early_read();
        test_free_run();
        summarize();
    end

    initial begin
        #(50 * 20000);
        miscompares++;
        summarize();
    end
endmodule

`default_nettype wire
